// >>> hw/utc_consts.svh
/*
 Register addresses, bit positions and reset values of the transceiver
 control and status bank. Included by the register bank module only.
*/
`ifndef UTC_CONSTS_SVH
`define UTC_CONSTS_SVH
// ==========================================
// Nibble space addresses
`define UTC_N_PWR 4'h0
`define UTC_N_ACT 4'h1
`define UTC_N_ACTC 4'h2
`define UTC_N_IST 4'h3
`define UTC_N_IMSK 4'h4
`define UTC_N_BEAR 4'h5
`define UTC_N_MSG 4'h6
// ==========================================
// Byte space addresses
`define UTC_B_TXM4 4'h0
`define UTC_B_RXM4 4'h1
`define UTC_B_TXM56 4'h2
`define UTC_B_RXM56 4'h3
`define UTC_B_FEBE 4'h4
`define UTC_B_NEBE 4'h5
`define UTC_B_LOOP 4'h6
`define UTC_B_LCFG 4'h7
`define UTC_B_FRM 4'h8
`define UTC_B_MMODE 4'h9
`define UTC_B_RSVD 4'hA
`define UTC_B_ACTSM 4'hB
`define UTC_B_CPU 4'hC
`define UTC_B_EC 4'hD
`define UTC_B_DIAG 4'hE
`define UTC_B_REV 4'hF
// ==========================================
// Bit positions
`define UTC_PWR_SWRST 3
`define UTC_PWR_APD 1
`define UTC_PWR_RTN 0
`define UTC_ST_LINK 3
`define UTC_ST_SYNC 1
`define UTC_AC_SFUD 1
`define UTC_LCFG_ALT 7
`define UTC_DIAG_RB 6
`define UTC_CMD_RD 7
`define UTC_CMD_BYTE 4
`define UTC_MM_MSG_HI 7
`define UTC_MM_MSG_LO 6
`define UTC_MM_G4_HI 5
`define UTC_MM_G4_LO 4
`define UTC_MM_M56_HI 3
`define UTC_MM_M56_LO 2
// ==========================================
// Reset values and counts
`define UTC_MSG_ONES 12'hFFF
`define UTC_BYTE_ONES 8'hFF
`define UTC_M56_ONES 3'h7
`define UTC_CNT_MAX 8'hFF
`define UTC_FALL_MASK 4'hB
`define UTC_CMD_LAST 5'h07
`define UTC_LEN_SHORT 5'h10
`define UTC_LEN_LONG 5'h18
`define UTC_REV_W 5
`endif

// >>> hw/utc_pkg.sv
/*
 Types shared by the transceiver register bank: serial port states and
 the structs that carry line-side status in and controls out.
 Assumes the line datapath runs on the same clock as the bank.
*/
package utc_pkg;
	typedef enum logic [1:0] {PS_IDLE, PS_CMD, PS_DATA} utc_ps_t;
	typedef struct packed {
		logic [3:0] act_stat;
		logic [2:0] irq_src;
		logic rx_sf_end;
		logic rx_eoc;
		logic [11:0] rx_msg;
		logic [7:0] rx_g4;
		logic [2:0] rx_m56;
		logic febe_rx;
		logic crc_err;
		logic [2:0] rx_flags;
		logic tx_sf_bnd;
		logic tx_eoc_bnd;
		logic [7:0] frame_stat;
		logic [7:0] act_state;
		logic [15:0] err_pwr;
	} utc_line_in_t;
	typedef struct packed {
		logic [3:0] pwr;
		logic [3:0] act_ctl;
		logic [2:0] bearer;
		logic [11:0] tx_msg;
		logic [7:0] tx_g4;
		logic [2:0] tx_m56;
		logic febe_sel;
		logic [7:0] loopback;
		logic [7:0] link_cfg;
		logic [7:0] frame_ctl;
		logic [7:0] act_sm_ctl;
		logic [7:0] cpu_ctl;
		logic [7:0] ec_ctl;
		logic [7:0] diag;
		logic [7:0] clk_test;
	} utc_line_out_t;
endpackage

// >>> hw/utc_regs.sv
/*
 Control and status register bank of the line transceiver, reached over
 the serial control port. Assumes line-side inputs are on clk; the port
 pins come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`include "utc_consts.svh"

// Functional notes
// - Six nibble registers, a 12-bit message register, sixteen bytes, one alternate.
// - Power/reset nibble cleared only by hardware reset, kept over soft reset.
// - Absolute power-down makes the power nibble write-only.
// - Activation status cleared by resets; listed edges raise status bit 3.
// - Activation control holds request, deactivate, update disable, enable.
// - Interrupt status read-only; output asserts on any enabled set bit.
// - Mask nibble enables matching status bits; cleared by both resets.
// - Status bit 3 has highest priority, bit 0 lowest.
// - Bearer control: block first, block second, swap; bit 3 reserved.
// - Message register is 12 bits, double buffered, mode-steered.
// - Reads give received message; writes sent at next message boundary.
// - Transmit message latches go to all ones on either reset.
// - Transmit group-four byte double buffered, ones on reset.
// - Receive group-four byte updated per its mode field.
// - Transmit reserved bits 7..5 sent only while update disable is 0.
// - Receive reserved byte captures bits and reports receiver status.
// - Far-end counter survives resets and loads written values.
// - Far-end counter increments per flagged superframe, saturates.
// - Far-end counter counts only with sync and link-up.
// - Link config bit 7 steers byte address 15 to the alternate register.
// - Readback mode returns written control values of split registers.
// - Near-end error counted on check mismatch or link-up without sync.
module utc_regs #(
	parameter logic [`UTC_REV_W-1:0] REV = 5'h01 // Value is arbitrary.
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ser_clk,
	input wire logic ser_en_n,
	input wire logic ser_din,
	output logic ser_dout,
	output logic ser_dout_oe_n,
	input utc_pkg::utc_line_in_t line_in,
	output utc_pkg::utc_line_out_t line_out,
	output logic irq,
	output logic [1:0] irq_lvl
);
	import utc_pkg::*;

	// ==========================================
	// Pin synchronisers
	logic [2:0] sck_s;
	logic [2:0] en_s;
	logic [1:0] din_s;
	always_ff @(posedge clk) begin
		sck_s <= {sck_s[1:0], ser_clk};
		en_s <= {en_s[1:0], ser_en_n};
		din_s <= {din_s[0], ser_din};
	end
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire frame_on = ~en_s[1];
	wire frame_end = en_s[1] & ~en_s[2];
	wire din = din_s[1];

	// ==========================================
	// Serial frame: command byte, then 8 or 16 data bits, MSB first
	utc_ps_t st_q;
	logic [4:0] cnt_q;
	logic [7:0] cmd_q;
	logic [15:0] dat_q;
	logic [15:0] sho_q;
	logic dout_q;
	logic oe_n_q;
	wire [7:0] cmd_nx = {cmd_q[6:0], din};
	wire in_cmd = (st_q == PS_IDLE) || (st_q == PS_CMD);
	wire cmd_done = frame_on && sck_rise && in_cmd && cnt_q == `UTC_CMD_LAST;
	wire is_byte = cmd_q[`UTC_CMD_BYTE];
	wire [3:0] adr = cmd_q[3:0];
	wire nx_msg = ~cmd_nx[`UTC_CMD_BYTE] && cmd_nx[3:0] == `UTC_N_MSG;
	wire is_msg = ~is_byte && adr == `UTC_N_MSG;
	wire [4:0] flen = is_msg ? `UTC_LEN_LONG : `UTC_LEN_SHORT;
	// A short or over-long frame is dropped whole.
	wire wr_go = frame_end && st_q == PS_DATA && cnt_q == flen &&
		~cmd_q[`UTC_CMD_RD];
	wire [15:0] wd = dat_q;
	logic [15:0] rd_data;
	wire rd_ist = cmd_done && cmd_nx[`UTC_CMD_RD] &&
		~cmd_nx[`UTC_CMD_BYTE] && cmd_nx[3:0] == `UTC_N_IST;

	function automatic logic wsel(input logic go, input logic bsp,
		input logic [3:0] a, input logic want_b, input logic [3:0] want_a);
		wsel = go && bsp == want_b && a == want_a;
	endfunction

	function automatic logic upd_ok(input logic [1:0] mode,
		input logic sync);
		// Mode 0 updates always, 1 only in sync, 2 and 3 freeze.
		case (mode)
			2'd0: upd_ok = 1'b1;
			2'd1: upd_ok = sync;
			default: upd_ok = 1'b0;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= PS_IDLE;
			cnt_q <= 5'h00;
			cmd_q <= 8'h00;
			dat_q <= 16'h0000;
			sho_q <= 16'h0000;
		end else if (!frame_on) begin
			st_q <= PS_IDLE;
			cnt_q <= 5'h00;
		end else if (sck_rise) begin
			if (cnt_q != 5'h1F)
				cnt_q <= cnt_q + 5'd1;
			case (st_q)
				PS_IDLE, PS_CMD: begin
					cmd_q <= cmd_nx;
					st_q <= (cnt_q == `UTC_CMD_LAST) ? PS_DATA : PS_CMD;
					// Read data is caught once so a frame reads one snapshot.
					if (cnt_q == `UTC_CMD_LAST)
						sho_q <= nx_msg ? rd_data : {rd_data[7:0], 8'h00};
				end
				PS_DATA: dat_q <= {dat_q[14:0], din};
				default: st_q <= PS_IDLE;
			endcase
		end else if (sck_fall && st_q == PS_DATA) begin
			sho_q <= {sho_q[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dout_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			if (sck_fall && st_q == PS_DATA)
				dout_q <= sho_q[15];
			oe_n_q <= ~(frame_on && st_q == PS_DATA && cmd_q[`UTC_CMD_RD]);
		end
	end

	// ==========================================
	// Control and status registers
	logic [3:0] pwr_q, act_q, actc_q, ist_q, imsk_q;
	logic [2:0] bear_q;
	logic [11:0] msg_wr_q, tx_msg_q, rx_msg_q;
	logic [7:0] g4_wr_q, tx_g4_q, rx_g4_q, m56_wr_q;
	logic [2:0] tx_m56_q, rx_m56_q;
	logic [4:0] rx_st_q;
	logic [7:0] febe_q, nebe_q, loop_q, lcfg_q, frm_q, mm_q;
	logic [7:0] actsm_q, cpu_q, ec_q, diag_q, ctest_q;
	logic irq_q;
	logic [1:0] lvl_q;
	wire swr = srst | pwr_q[`UTC_PWR_SWRST];
	wire sync = act_q[`UTC_ST_SYNC];
	wire link = act_q[`UTC_ST_LINK];
	wire rb = diag_q[`UTC_DIAG_RB];
	wire [3:0] ast = line_in.act_stat;
	wire act_evt = |(~act_q & ast) | |(act_q & ~ast & `UTC_FALL_MASK);
	wire [3:0] ist_d = {act_evt, line_in.irq_src} |
		(ist_q & {4{~rd_ist}});
	wire [3:0] pend = ist_d & imsk_q;
	wire alt = lcfg_q[`UTC_LCFG_ALT];
	wire w_febe = wsel(wr_go, is_byte, adr, 1'b1, `UTC_B_FEBE);
	wire w_nebe = wsel(wr_go, is_byte, adr, 1'b1, `UTC_B_NEBE);
	wire sf_end = line_in.rx_sf_end;
	wire febe_inc = sf_end && line_in.febe_rx && sync && link;
	wire nebe_inc = sf_end && (line_in.crc_err || (link && !sync));

	always_ff @(posedge clk) begin
		if (srst)
			pwr_q <= 4'h0;
		else if (wsel(wr_go, is_byte, adr, 1'b0, `UTC_N_PWR))
			pwr_q <= wd[3:0];
	end

	always_ff @(posedge clk) begin
		if (swr) begin
			act_q <= 4'h0;
			ist_q <= 4'h0;
			irq_q <= 1'b0;
			lvl_q <= 2'd0;
		end else begin
			act_q <= ast;
			ist_q <= ist_d;
			irq_q <= |pend;
			lvl_q <= pend[3] ? 2'd3 : pend[2] ? 2'd2 :
				pend[1] ? 2'd1 : 2'd0;
		end
	end

	// Plain read/write control registers share one reset and write style.
	always_ff @(posedge clk) begin
		if (swr) begin
			actc_q <= 4'h0;
			imsk_q <= 4'h0;
			bear_q <= 3'h0;
			lcfg_q <= 8'h00;
			frm_q <= 8'h00;
			mm_q <= 8'h00;
			actsm_q <= 8'h00;
			cpu_q <= 8'h00;
			ec_q <= 8'h00;
			diag_q <= 8'h00;
			ctest_q <= 8'h00;
		end else if (wr_go) begin
			if (wsel(1'b1, is_byte, adr, 1'b0, `UTC_N_ACTC))
				actc_q <= wd[3:0];
			if (wsel(1'b1, is_byte, adr, 1'b0, `UTC_N_IMSK))
				imsk_q <= wd[3:0];
			if (wsel(1'b1, is_byte, adr, 1'b0, `UTC_N_BEAR))
				bear_q <= wd[2:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_LCFG))
				lcfg_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_FRM))
				frm_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_MMODE))
				mm_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_ACTSM))
				actsm_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_CPU))
				cpu_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_EC))
				ec_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_DIAG))
				diag_q <= wd[7:0];
			if (wsel(1'b1, is_byte, adr, 1'b1, `UTC_B_REV) && alt)
				ctest_q <= wd[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (swr || pwr_q[`UTC_PWR_RTN])
			loop_q <= 8'h00;
		else if (wsel(wr_go, is_byte, adr, 1'b1, `UTC_B_LOOP))
			loop_q <= wd[7:0];
	end

	// ==========================================
	// Double-buffered maintenance and message paths
	always_ff @(posedge clk) begin
		if (swr) begin
			msg_wr_q <= `UTC_MSG_ONES;
			tx_msg_q <= `UTC_MSG_ONES;
			g4_wr_q <= `UTC_BYTE_ONES;
			tx_g4_q <= `UTC_BYTE_ONES;
			m56_wr_q <= `UTC_BYTE_ONES;
			tx_m56_q <= `UTC_M56_ONES;
		end else begin
			if (wsel(wr_go, is_byte, adr, 1'b0, `UTC_N_MSG))
				msg_wr_q <= wd[11:0];
			if (line_in.tx_eoc_bnd)
				tx_msg_q <= msg_wr_q;
			if (wsel(wr_go, is_byte, adr, 1'b1, `UTC_B_TXM4))
				g4_wr_q <= wd[7:0];
			if (line_in.tx_sf_bnd)
				tx_g4_q <= g4_wr_q;
			if (wsel(wr_go, is_byte, adr, 1'b1, `UTC_B_TXM56))
				m56_wr_q <= wd[7:0];
			if (line_in.tx_sf_bnd && !actc_q[`UTC_AC_SFUD])
				tx_m56_q <= m56_wr_q[7:5];
		end
	end

	always_ff @(posedge clk) begin
		if (swr) begin
			rx_msg_q <= 12'h000;
			rx_g4_q <= 8'h00;
			rx_m56_q <= 3'h0;
			rx_st_q <= 5'h00;
		end else begin
			if (line_in.rx_eoc &&
				upd_ok(mm_q[`UTC_MM_MSG_HI:`UTC_MM_MSG_LO], sync))
				rx_msg_q <= line_in.rx_msg;
			if (sf_end && upd_ok(mm_q[`UTC_MM_G4_HI:`UTC_MM_G4_LO], sync))
				rx_g4_q <= line_in.rx_g4;
			if (sf_end &&
				upd_ok(mm_q[`UTC_MM_M56_HI:`UTC_MM_M56_LO], sync))
				rx_m56_q <= line_in.rx_m56;
			if (sf_end)
				rx_st_q <= {line_in.febe_rx, line_in.crc_err,
					line_in.rx_flags};
		end
	end

	// Error counters keep their count through every reset.
	always_ff @(posedge clk) begin
		if (w_febe)
			febe_q <= wd[7:0];
		else if (febe_inc && febe_q != `UTC_CNT_MAX)
			febe_q <= febe_q + 8'd1;
		if (w_nebe)
			nebe_q <= wd[7:0];
		else if (nebe_inc && nebe_q != `UTC_CNT_MAX)
			nebe_q <= nebe_q + 8'd1;
	end

	// ==========================================
	// Read selection, addressed by the command being completed
	wire [3:0] ra = cmd_nx[3:0];
	wire [7:0] frm_rd = rb ? frm_q : line_in.frame_stat;
	wire [7:0] asm_rd = rb ? actsm_q : line_in.act_state;
	wire [7:0] cpu_rd = rb ? cpu_q : line_in.err_pwr[15:8];
	wire [7:0] ec_rd = rb ? ec_q : line_in.err_pwr[7:0];
	wire [7:0] rev_rd = alt ? ctest_q : {3'h0, REV};
	logic [7:0] byte_rd;
	logic [11:0] nib_rd;
	always_comb begin
		case (ra)
			`UTC_B_TXM4: byte_rd = g4_wr_q;
			`UTC_B_RXM4: byte_rd = rx_g4_q;
			`UTC_B_TXM56: byte_rd = m56_wr_q;
			`UTC_B_RXM56: byte_rd = {rx_m56_q, rx_st_q};
			`UTC_B_FEBE: byte_rd = febe_q;
			`UTC_B_NEBE: byte_rd = nebe_q;
			`UTC_B_LOOP: byte_rd = loop_q;
			`UTC_B_LCFG: byte_rd = lcfg_q;
			`UTC_B_FRM: byte_rd = frm_rd;
			`UTC_B_MMODE: byte_rd = mm_q;
			`UTC_B_ACTSM: byte_rd = asm_rd;
			`UTC_B_CPU: byte_rd = cpu_rd;
			`UTC_B_EC: byte_rd = ec_rd;
			`UTC_B_DIAG: byte_rd = diag_q;
			`UTC_B_REV: byte_rd = rev_rd;
			default: byte_rd = 8'h00;
		endcase
		case (ra)
			`UTC_N_PWR: nib_rd = pwr_q[`UTC_PWR_APD] ?
				12'h000 : {8'h00, pwr_q};
			`UTC_N_ACT: nib_rd = {8'h00, act_q};
			`UTC_N_ACTC: nib_rd = {8'h00, actc_q};
			`UTC_N_IST: nib_rd = {8'h00, ist_q};
			`UTC_N_IMSK: nib_rd = {8'h00, imsk_q};
			`UTC_N_BEAR: nib_rd = {9'h000, bear_q};
			`UTC_N_MSG: nib_rd = rb ? msg_wr_q : rx_msg_q;
			default: nib_rd = 12'h000;
		endcase
	end
	assign rd_data = cmd_nx[`UTC_CMD_BYTE] ? {8'h00, byte_rd} :
		{4'h0, nib_rd};

	// ==========================================
	// Outputs
	assign ser_dout = dout_q;
	assign ser_dout_oe_n = oe_n_q;
	assign irq = irq_q;
	assign irq_lvl = lvl_q;
	assign line_out = '{pwr: pwr_q, act_ctl: actc_q, bearer: bear_q,
		tx_msg: tx_msg_q, tx_g4: tx_g4_q, tx_m56: tx_m56_q,
		febe_sel: m56_wr_q[4], loopback: loop_q, link_cfg: lcfg_q,
		frame_ctl: frm_q, act_sm_ctl: actsm_q, cpu_ctl: cpu_q,
		ec_ctl: ec_q, diag: diag_q, clk_test: ctest_q};

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	pwr_keep_a: assert property (pwr_q[3] && !wr_go |=> $stable(pwr_q))
		else $error("power nibble lost over soft reset");
	apd_read_a: assert property (cmd_done && !cmd_nx[`UTC_CMD_BYTE] &&
		ra == `UTC_N_PWR && pwr_q[`UTC_PWR_APD] |->
		rd_data == 16'h0000)
		else $error("power nibble readable in power-down");
	act_irq_a: assert property (act_q[3] && !ast[3] && !swr |=>
		ist_q[3])
		else $error("link-up fall did not raise status");
	irq_out_a: assert property (ist_q[3] && imsk_q[3] && !rd_ist && !swr
		|=> irq && irq_lvl == 2'd3)
		else $error("top interrupt not signalled");
	mask_clr_a: assert property (pwr_q[3] |=> imsk_q == 4'h0)
		else $error("mask kept over soft reset");
	msg_ones_a: assert property (pwr_q[3] |=> tx_msg_q == 12'hFFF)
		else $error("message latch not ones after reset");
	msg_send_a: assert property (line_in.tx_eoc_bnd && !swr |=>
		tx_msg_q == $past(msg_wr_q))
		else $error("message not sent at boundary");
	febe_sat_a: assert property (febe_q == 8'hFF && !w_febe |=>
		febe_q == 8'hFF)
		else $error("far-end counter wrapped");
	febe_gate_a: assert property (sf_end && !(sync && link) && !w_febe
		|=> $stable(febe_q))
		else $error("far-end counter moved without sync");
	m56_hold_a: assert property (line_in.tx_sf_bnd && actc_q[1] && !swr
		|=> $stable(tx_m56_q))
		else $error("reserved bits sent while disabled");
	irq_mask_a: assert property (imsk_q == 4'h0 && !swr |=> !irq)
		else $error("interrupt with all enables clear");
endmodule

// >>> tb/utc_host_model.sv
/*
 Behavioural controller that drives the serial control port of the bank.
 Assumes the bench calls xfer for one frame at a time, never overlapping.
*/
`timescale 1ns/1ps
// ==========================================
// Serial port master
module utc_host_model (
	output logic ser_clk,
	output logic ser_en_n,
	output logic ser_din,
	input wire logic ser_dout
);
	initial begin
		ser_clk = 1'b1;
		ser_en_n = 1'b1;
		ser_din = 1'b0;
	end
	// The clock idles high and stands still between frames.
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat,
		input int nd, output logic [15:0] rd);
		logic [23:0] sh;
		// Short frames carry their data in the low byte, so only the data
		// part is aligned; the command must stay in the top byte.
		sh = {cmd, dat << (16 - nd)};
		rd = 16'h0000;
		ser_en_n = 1'b0;
		#32;
		for (int i = 0; i < 8 + nd; i++) begin
			ser_clk = 1'b0;
			ser_din = sh[23];
			sh = sh << 1;
			#32;
			ser_clk = 1'b1;
			if (i >= 8)
				rd = {rd[14:0], ser_dout};
			#32;
		end
		ser_en_n = 1'b1;
		// The data line has no pull, so a released line must not look held.
		ser_din = ~ser_din;
		#64;
	endtask
endmodule

// >>> tb/tb.sv
/*
 Self-checking bench for the transceiver register bank.
 Assumes the bank and the controller model; the line side is driven here.
*/
`timescale 1ns/1ps
module tb;
	import utc_pkg::*;
	localparam logic [4:0] REV_T = 5'h0B; // Value is arbitrary.
	logic clk = 1'b0;
	logic srst = 1'b1;
	wire ser_clk;
	wire ser_en_n;
	wire ser_din;
	logic ser_dout;
	logic ser_dout_oe_n;
	logic irq;
	logic [1:0] irq_lvl;
	utc_line_in_t li = '0;
	utc_line_out_t lo;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 32'h9573;
	logic [15:0] mdl [32];
	logic [15:0] v;
	logic [7:0] rwa [6] = '{8'h02, 8'h04, 8'h05, 8'h16, 8'h17, 8'h19};
	logic [7:0] rwm [6] = '{8'h0F, 8'h0F, 8'h07, 8'hFF, 8'h7F, 8'hFF};
	always #2.5 clk = ~clk;
	utc_regs #(.REV(REV_T)) uut (
		.clk(clk),
		.srst(srst),
		.ser_clk(ser_clk),
		.ser_en_n(ser_en_n),
		.ser_din(ser_din),
		.ser_dout(ser_dout),
		.ser_dout_oe_n(ser_dout_oe_n),
		.line_in(li),
		.line_out(lo),
		.irq(irq),
		.irq_lvl(irq_lvl)
	);
	utc_host_model host (
		.ser_clk(ser_clk),
		.ser_en_n(ser_en_n),
		.ser_din(ser_din),
		.ser_dout(ser_dout)
	);
	// ==========================================
	// Checking and access tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic int nbits(input logic [7:0] c);
		return (c[4:0] == 5'h06) ? 16 : 8;
	endfunction
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		logic [15:0] r;
		host.xfer(c, d, nbits(c), r);
		mdl[c[4:0]] = d;
	endtask
	task automatic rc(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] r;
		host.xfer(c | 8'h80, 16'h0000, nbits(c), r);
		chk(r, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle line pulse: 0 rx end, 1 rx message, 2 tx sf, 3 tx message.
	task automatic pl(input int k, input logic [2:0] s);
		tick(1);
		li.irq_src = s;
		li.rx_sf_end = (k == 0);
		li.rx_eoc = (k == 1);
		li.tx_sf_bnd = (k == 2);
		li.tx_eoc_bnd = (k == 3);
		tick(1);
		li.irq_src = 3'b000;
		li.rx_sf_end = 1'b0;
		li.rx_eoc = 1'b0;
		li.tx_sf_bnd = 1'b0;
		li.tx_eoc_bnd = 1'b0;
		tick(3);
	endtask
	task automatic st(input logic [3:0] a);
		tick(1);
		li.act_stat = a;
		tick(3);
	endtask
	// ==========================================
	// Timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			end_sim();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		tick(4);
		srst = 1'b0;
		tick(3);
		chk(16'(lo.tx_msg), 16'h0FFF);
		chk(16'(lo.tx_g4), 16'h00FF);
		chk(16'(ser_dout_oe_n), 16'h0001);
		chk(16'(lo.tx_m56), 16'h0007);
		for (int i = 0; i < 6; i++)
			rc(8'(i), 16'h0000);
		rc(8'h10, 16'h00FF);
		rc(8'h12, 16'h00FF);
		rc(8'h1A, 16'h0000);
		// The counters power up unknown, so give them a value first.
		wr(8'h14, 16'h0000);
		wr(8'h15, 16'h0000);
		for (int k = 0; k < 3; k++)
			for (int i = 0; i < 6; i++) begin
				v = 16'($random(seed)) & {8'h00, rwm[i]};
				wr(rwa[i], v);
				rc(rwa[i], mdl[rwa[i][4:0]]);
			end
		// Soft reset leaves only the power nibble and the counters alone.
		wr(8'h00, 16'h0008);
		rc(8'h00, 16'h0008);
		rc(8'h02, 16'h0000);
		rc(8'h04, 16'h0000);
		rc(8'h05, 16'h0000);
		wr(8'h00, 16'h0002);
		rc(8'h00, 16'h0000);
		chk(16'(lo.pwr), 16'h0002);
		wr(8'h00, 16'h0000);
		wr(8'h16, 16'h005A);
		wr(8'h00, 16'h0001);
		rc(8'h16, 16'h0000);
		chk(16'(lo.loopback), 16'h0000);
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h000F);
		rc(8'h03, 16'h0000);
		pl(4, 3'b001);
		chk(16'(irq), 16'h0001);
		chk(16'(irq_lvl), 16'h0000);
		pl(4, 3'b100);
		chk(16'(irq_lvl), 16'h0002);
		st(4'h8);
		chk(16'(irq_lvl), 16'h0003);
		rc(8'h01, 16'h0008);
		rc(8'h03, 16'h000D);
		chk(16'(irq), 16'h0000);
		wr(8'h04, 16'h0001);
		pl(4, 3'b010);
		chk(16'(irq), 16'h0000);
		st(4'h0);
		rc(8'h03, 16'h000A);
		st(4'h4);
		rc(8'h03, 16'h0008);
		st(4'h0);
		rc(8'h03, 16'h0000);
		wr(8'h04, 16'h0000);
		wr(8'h19, 16'h0000);
		wr(8'h06, 16'h0A5C);
		pl(3, 3'b000);
		chk(16'(lo.tx_msg), 16'h0A5C);
		tick(1);
		li.rx_msg = 12'h3C7;
		pl(1, 3'b000);
		rc(8'h06, 16'h03C7);
		wr(8'h18, 16'h00C3);
		rc(8'h18, 16'h0000);
		wr(8'h1E, 16'h0040);
		rc(8'h06, 16'h0A5C);
		rc(8'h18, 16'h00C3);
		wr(8'h1E, 16'h0000);
		wr(8'h19, 16'h0080);
		tick(1);
		li.rx_msg = 12'h111;
		pl(1, 3'b000);
		rc(8'h06, 16'h03C7);
		wr(8'h10, 16'h003C);
		pl(2, 3'b000);
		chk(16'(lo.tx_g4), 16'h003C);
		wr(8'h02, 16'h0002);
		chk(16'(lo.act_ctl), 16'h0002);
		wr(8'h12, 16'h00A0);
		pl(2, 3'b000);
		chk(16'(lo.tx_m56), 16'h0007);
		wr(8'h02, 16'h0000);
		pl(2, 3'b000);
		chk(16'(lo.tx_m56), 16'h0005);
		wr(8'h19, 16'h0010);
		tick(1);
		li.act_stat = 4'h2;
		li.rx_g4 = 8'h96;
		li.rx_m56 = 3'b101;
		li.rx_flags = 3'b011;
		li.febe_rx = 1'b1;
		pl(0, 3'b000);
		rc(8'h11, 16'h0096);
		rc(8'h13, 16'h00B3);
		st(4'h0);
		li.rx_g4 = 8'h55;
		pl(0, 3'b000);
		rc(8'h11, 16'h0096);
		rc(8'h14, 16'h0000);
		// Far-end counter: gated by sync and link-up, then saturating.
		wr(8'h14, 16'h0010);
		st(4'h8);
		pl(0, 3'b000);
		st(4'h2);
		pl(0, 3'b000);
		rc(8'h14, 16'h0010);
		st(4'hA);
		pl(0, 3'b000);
		rc(8'h14, 16'h0011);
		wr(8'h14, 16'h00FD);
		for (int i = 0; i < 3; i++) begin
			pl(0, 3'b000);
			rc(8'h14, 16'((i < 2) ? 254 + i : 255));
		end
		wr(8'h15, 16'h0020);
		tick(1);
		li.crc_err = 1'b1;
		pl(0, 3'b000);
		li.crc_err = 1'b0;
		st(4'h8);
		pl(0, 3'b000);
		rc(8'h15, 16'h0022);
		wr(8'h00, 16'h0008);
		wr(8'h00, 16'h0004);
		rc(8'h14, 16'h00FF);
		tick(1);
		srst = 1'b1;
		tick(4);
		srst = 1'b0;
		tick(3);
		rc(8'h14, 16'h00FF);
		rc(8'h00, 16'h0000);
		chk(16'(lo.tx_g4), 16'h00FF);
		rc(8'h1F, 16'(REV_T));
		wr(8'h17, 16'h0080);
		wr(8'h1F, 16'h000F);
		chk(16'(lo.clk_test), 16'h000F);
		rc(8'h1F, 16'h000F);
		wr(8'h17, 16'h0000);
		rc(8'h1F, 16'(REV_T));
		end_sim();
	end
endmodule
